// ---- rtl/twrs_pkg.sv ----
package twrs_pkg;

   // Bus address the slave answers to
   localparam logic [6:0] TWRS_DEV_ADDR = 7'h74;

   // Bit positions inside a received first byte
   localparam int TWRS_RW_BIT   = 0;
   localparam int TWRS_ADDR_MSB = 7;
   localparam int TWRS_ADDR_LSB = 1;

   // Index of the last bit of a byte in the bit counter
   localparam logic [2:0] TWRS_LAST_BIT = 3'h7;

   // Reset values
   localparam logic [7:0] TWRS_PTR_RST  = 8'h00;
   localparam logic [7:0] TWRS_REG_RST  = 8'h00;
   localparam logic [2:0] TWRS_CNT_RST  = 3'h0;

   // Timing
   localparam int TWRS_CLK_MHZ       = 100;
   localparam int TWRS_RST_LOW_MIN_NS = 1000;
   localparam int TWRS_RST_LOW_MIN_CYC = (TWRS_RST_LOW_MIN_NS * TWRS_CLK_MHZ + 999) / 1000;
   localparam int TWRS_MAX_KBPS      = 100;
   localparam int TWRS_BIT_MIN_CYC   = (TWRS_CLK_MHZ * 1000) / TWRS_MAX_KBPS;

   typedef enum logic [8:0]
   {
      TWRS_IDLE = 9'h001,
      TWRS_ADDR = 9'h002,
      TWRS_ACKW = 9'h004,
      TWRS_ACK  = 9'h008,
      TWRS_RX   = 9'h010,
      TWRS_TX   = 9'h020,
      TWRS_MACK = 9'h040,
      TWRS_TXNX = 9'h080,
      TWRS_SKIP = 9'h100
   } twrs_state_e;

   typedef struct packed
   {
      twrs_state_e       state;
      logic              scl_s1;
      logic              scl_s2;
      logic              scl_s3;
      logic              sda_s1;
      logic              sda_s2;
      logic              sda_s3;
      logic [7:0]        shift;
      logic [2:0]        cnt;
      logic [7:0]        ptr;
      logic              rd;
      logic              data_phase;
      logic              sda_oe;
      logic              wr_tgl;
      logic [7:0]        wr_addr;
      logic [7:0]        wr_data;
      logic              live_s1;
      logic              live_s2;
   } twrs_bus_s;

   typedef struct packed
   {
      logic       tgl_s1;
      logic       tgl_s2;
      logic       tgl_s3;
      logic       sleep_s1;
      logic       sleep_s2;
      logic       sleep_s3;
      logic       live_s1;
      logic       live_s2;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } twrs_core_s;

endpackage

// ---- rtl/two_wire_register_slave.sv ----
`timescale 1ns/100ps
module two_wire_register_slave
(
   input  wire logic       clock_i,
   input  wire logic       sys_rst_i,
   input  wire logic       global_reset_low_i,
   input  wire logic       external_clock_in_i,
   input  wire logic       sleep_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   output logic            core_wr_o,
   output logic [7:0]      core_wr_addr_o,
   output logic [7:0]      core_wr_data_o,
   output logic            core_asleep_o
);

   twrs_pkg::twrs_bus_s  b;
   twrs_pkg::twrs_bus_s  next_b;
   twrs_pkg::twrs_core_s c;
   twrs_pkg::twrs_core_s next_c;

   logic       scl_rise;
   logic       scl_fall;
   logic       start_seen;
   logic       stop_seen;
   logic [7:0] rx_byte;
   logic [7:0] tx_word;

   // Register store, kept out of the state struct so a cycle copies no 2 kbit word
   logic       store_we;
   logic [7:0] store_addr;
   logic [7:0] store_din;
   logic [7:0] store [256];

   // Synchronisers reset to the idle bus level, so no false edge follows reset
   localparam twrs_pkg::twrs_bus_s BUS_RST = '{
      state      : twrs_pkg::TWRS_IDLE,
      scl_s1     : 1'b1,
      scl_s2     : 1'b1,
      scl_s3     : 1'b1,
      sda_s1     : 1'b1,
      sda_s2     : 1'b1,
      sda_s3     : 1'b1,
      shift      : 8'h00,
      cnt        : twrs_pkg::TWRS_CNT_RST,
      ptr        : twrs_pkg::TWRS_PTR_RST,
      wr_addr    : 8'h00,
      wr_data    : 8'h00,
      default    : 1'b0
   };

   localparam twrs_pkg::twrs_core_s CORE_RST = '{
      addr    : 8'h00,
      data    : 8'h00,
      default : 1'b0
   };

   // Edges are taken from the second and third stages only
   assign scl_rise   = b.scl_s2 & ~b.scl_s3;
   assign scl_fall   = ~b.scl_s2 & b.scl_s3;
   assign start_seen = b.scl_s2 & b.scl_s3 & b.sda_s3 & ~b.sda_s2;
   assign stop_seen  = b.scl_s2 & b.scl_s3 & ~b.sda_s3 & b.sda_s2;
   assign rx_byte    = {b.shift[6:0], b.sda_s2};
   assign tx_word    = store[b.ptr];

   always_comb
   begin
      next_b        = b;
      // Pure slave: SCL is sampled here and never driven
      next_b.scl_s1 = scl_i;
      next_b.scl_s2 = b.scl_s1;
      next_b.scl_s3 = b.scl_s2;
      next_b.sda_s1 = sda_i;
      next_b.sda_s2 = b.sda_s1;
      next_b.sda_s3 = b.sda_s2;
      next_b.live_s1 = 1'b1;
      next_b.live_s2 = b.live_s1;

      store_we       = 1'b0;
      store_addr     = b.ptr;
      store_din      = rx_byte;

      // Release of the asynchronous reset is retimed here, so the engine
      // leaves reset at one known edge rather than a metastable one
      if (!b.live_s2)
      begin
         next_b.state  = twrs_pkg::TWRS_IDLE;
         next_b.sda_oe = 1'b0;
      end
      else if (stop_seen)
      begin
         next_b.state  = twrs_pkg::TWRS_IDLE;
         next_b.sda_oe = 1'b0;
      end
      else if (start_seen)
      begin
         // A repeated start lands here too and restarts address reception
         next_b.state      = twrs_pkg::TWRS_ADDR;
         next_b.cnt        = twrs_pkg::TWRS_CNT_RST;
         next_b.sda_oe     = 1'b0;
         next_b.data_phase = 1'b0;
      end
      else
      begin
         case (b.state)
            twrs_pkg::TWRS_ADDR:
            begin
               if (scl_rise)
               begin
                  next_b.shift = rx_byte;
                  next_b.cnt   = 3'(b.cnt + 3'h1);
                  if (b.cnt == twrs_pkg::TWRS_LAST_BIT)
                  begin
                     if (rx_byte[twrs_pkg::TWRS_ADDR_MSB:twrs_pkg::TWRS_ADDR_LSB] == twrs_pkg::TWRS_DEV_ADDR)
                     begin
                        next_b.rd    = rx_byte[twrs_pkg::TWRS_RW_BIT];
                        next_b.state = twrs_pkg::TWRS_ACKW;
                     end
                     else
                     begin
                        next_b.state = twrs_pkg::TWRS_SKIP;
                     end
                  end
               end
            end
            twrs_pkg::TWRS_RX:
            begin
               if (scl_rise)
               begin
                  next_b.shift = rx_byte;
                  next_b.cnt   = 3'(b.cnt + 3'h1);
                  if (b.cnt == twrs_pkg::TWRS_LAST_BIT)
                  begin
                     next_b.state = twrs_pkg::TWRS_ACKW;
                     if (!b.data_phase)
                     begin
                        next_b.ptr        = rx_byte;
                        next_b.data_phase = 1'b1;
                     end
                     else
                     begin
                        // Further bytes land at successive addresses
                        store_we           = 1'b1;
                        next_b.wr_addr     = b.ptr;
                        next_b.wr_data     = rx_byte;
                        next_b.wr_tgl      = ~b.wr_tgl;
                        next_b.ptr         = 8'(b.ptr + 8'h01);
                     end
                  end
               end
            end
            twrs_pkg::TWRS_ACKW:
            begin
               // Wait for SCL low so SDA never moves while SCL is high
               if (scl_fall)
               begin
                  next_b.sda_oe = 1'b1;
                  next_b.state  = twrs_pkg::TWRS_ACK;
               end
            end
            twrs_pkg::TWRS_ACK:
            begin
               if (scl_fall)
               begin
                  next_b.cnt = twrs_pkg::TWRS_CNT_RST;
                  if (b.rd)
                  begin
                     // First read bit goes out at the fall that ends the ack
                     next_b.shift  = tx_word;
                     next_b.sda_oe = ~tx_word[7];
                     next_b.state  = twrs_pkg::TWRS_TX;
                  end
                  else
                  begin
                     next_b.sda_oe = 1'b0;
                     next_b.state  = twrs_pkg::TWRS_RX;
                  end
               end
            end
            twrs_pkg::TWRS_TX:
            begin
               if (scl_fall)
               begin
                  if (b.cnt == twrs_pkg::TWRS_LAST_BIT)
                  begin
                     next_b.sda_oe = 1'b0;
                     next_b.state  = twrs_pkg::TWRS_MACK;
                  end
                  else
                  begin
                     // Bit 7 is already out, so bit 6 is the next one
                     next_b.sda_oe = ~b.shift[6];
                     next_b.shift  = {b.shift[6:0], 1'b0};
                     next_b.cnt    = 3'(b.cnt + 3'h1);
                  end
               end
            end
            twrs_pkg::TWRS_MACK:
            begin
               if (scl_rise)
               begin
                  next_b.ptr = 8'(b.ptr + 8'h01);
                  // A nack ends the read; only a stop or start wakes us
                  next_b.state = b.sda_s2 ? twrs_pkg::TWRS_SKIP : twrs_pkg::TWRS_TXNX;
               end
            end
            twrs_pkg::TWRS_TXNX:
            begin
               if (scl_fall)
               begin
                  next_b.shift  = tx_word;
                  next_b.sda_oe = ~tx_word[7];
                  next_b.cnt    = twrs_pkg::TWRS_CNT_RST;
                  next_b.state  = twrs_pkg::TWRS_TX;
               end
            end
            twrs_pkg::TWRS_IDLE,
            twrs_pkg::TWRS_SKIP:
            begin
               next_b.sda_oe = 1'b0;
            end
            default:
            begin
               next_b.state  = twrs_pkg::TWRS_IDLE;
               next_b.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge global_reset_low_i)
   begin
      if (!global_reset_low_i)
      begin
         b <= BUS_RST;
      end
      else if (sys_rst_i)
      begin
         b <= BUS_RST;
      end
      else
      begin
         b <= next_b;
      end
   end

   // Register store: written only from the receive path, read through the
   // pointer when a byte goes out. Either reset clears every entry, so a read
   // after reset never returns data from before it.
   always_ff @(posedge clock_i or negedge global_reset_low_i)
   begin
      if (!global_reset_low_i)
      begin
         for (int i = 0; i < 256; i++)
         begin
            store[i] <= twrs_pkg::TWRS_REG_RST;
         end
      end
      else if (sys_rst_i)
      begin
         for (int i = 0; i < 256; i++)
         begin
            store[i] <= twrs_pkg::TWRS_REG_RST;
         end
      end
      else if (store_we)
      begin
         store[store_addr] <= store_din;
      end
   end

   // Core side: write events arrive as a toggle; address and data are held
   // stable for a whole byte time, far longer than the crossing takes.
   always_comb
   begin
      next_c          = c;
      next_c.tgl_s1   = b.wr_tgl;
      next_c.tgl_s2   = c.tgl_s1;
      next_c.tgl_s3   = c.tgl_s2;
      next_c.sleep_s1 = sleep_i;
      next_c.sleep_s2 = c.sleep_s1;
      next_c.sleep_s3 = c.sleep_s2;
      next_c.live_s1  = 1'b1;
      next_c.live_s2  = c.live_s1;
      next_c.wr       = 1'b0;
      // Writes seen while asleep are not replayed at wake; the gate reads one
      // stage ahead of the reported sleep level, so no write shows beside it
      if ((c.tgl_s2 != c.tgl_s3) && !c.sleep_s2 && c.live_s2)
      begin
         next_c.wr   = 1'b1;
         next_c.addr = b.wr_addr;
         next_c.data = b.wr_data;
      end
   end

   // The core side has no synchronous reset; only the global reset reaches it
   always_ff @(posedge external_clock_in_i or negedge global_reset_low_i)
   begin
      if (!global_reset_low_i)
      begin
         c <= CORE_RST;
      end
      else
      begin
         c <= next_c;
      end
   end

   assign sda_o          = 1'b0;
   assign sda_oe_o       = b.sda_oe;
   assign core_wr_o      = c.wr;
   assign core_wr_addr_o = c.addr;
   assign core_wr_data_o = c.data;
   assign core_asleep_o  = c.sleep_s3;

endmodule

// ---- testbench/twrs_chk.sv ----
`timescale 1ns/100ps
module twrs_chk
(
   input wire logic       clock_i,
   input wire logic       sys_rst_i,
   input wire logic       global_reset_low_i,
   input wire logic       external_clock_in_i,
   input wire logic       sleep_i,
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_o,
   input wire logic       core_wr_o,
   input wire logic [7:0] core_wr_addr_o,
   input wire logic [7:0] core_wr_data_o,
   input wire logic       core_asleep_o
);
   wire off = sys_rst_i || !global_reset_low_i;
   never_high_a: assert property (@(posedge clock_i) disable iff (off)
      sda_o == 1'b0) else $error("sda driven high");
   steady_high_a: assert property (@(posedge clock_i) disable iff (off)
      scl_i && $past(scl_i) |-> $stable(sda_oe_o)) else $error("sda moved in high phase");
   sync_lag_a: assert property (@(posedge clock_i) disable iff (off)
      $changed(sda_oe_o) |-> !scl_i && !$past(scl_i) && !$past(scl_i, 2)) else $error("sda moved too early");
   stop_idle_a: assert property (@(posedge clock_i) disable iff (off)
      scl_i && $past(scl_i) && $rose(sda_i) |=> !sda_oe_o [*8]) else $error("sda held after stop");
   start_quiet_a: assert property (@(posedge clock_i) disable iff (off)
      scl_i && $past(scl_i) && $fell(sda_i) |=> !sda_oe_o [*8]) else $error("sda held after start");
   reset_clear_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !global_reset_low_i |-> !sda_oe_o && !core_wr_o && !core_asleep_o) else $error("outputs live in reset");
   wr_strobe_a: assert property (@(posedge external_clock_in_i) disable iff (!global_reset_low_i)
      core_wr_o |=> !core_wr_o) else $error("write strobe too long");
   wr_hold_a: assert property (@(posedge external_clock_in_i) disable iff (!global_reset_low_i)
      !core_wr_o |-> $stable(core_wr_addr_o) && $stable(core_wr_data_o)) else $error("write fields moved");
   sleep_mute_a: assert property (@(posedge external_clock_in_i) disable iff (!global_reset_low_i)
      core_asleep_o |-> !core_wr_o) else $error("write while asleep");
   sleep_follow_a: assert property (@(posedge external_clock_in_i) disable iff (!global_reset_low_i)
      $rose(sleep_i) |-> ##[1:3] core_asleep_o) else $error("sleep not seen");
endmodule
bind two_wire_register_slave twrs_chk u_twrs_chk
(
   .clock_i,
   .sys_rst_i,
   .global_reset_low_i,
   .external_clock_in_i,
   .sleep_i,
   .scl_i,
   .sda_i,
   .sda_o,
   .sda_oe_o,
   .core_wr_o,
   .core_wr_addr_o,
   .core_wr_data_o,
   .core_asleep_o
);

// ---- testbench/twrs_master.sv ----
`timescale 1ns/100ps
module twrs_master
(
   input  wire logic clock_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      pull_o
);
   initial
   begin
      scl_o = 1'b1;
      pull_o = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   // Quarter-phase offsets keep SDA edges well away from SCL edges
   task automatic bit_x(input logic b, output logic r);
      wt(4);
      pull_o = !b;
      wt(4);
      scl_o = 1'b1;
      wt(8);
      r = sda_i;
      scl_o = 1'b0;
   endtask
   task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(d[i], q[i]);
      end
      bit_x(a, k);
   endtask
   task automatic start;
      wt(4);
      pull_o = 1'b0;
      wt(4);
      scl_o = 1'b1;
      wt(8);
      pull_o = 1'b1;
      wt(8);
      scl_o = 1'b0;
   endtask
   task automatic stop;
      wt(4);
      pull_o = 1'b1;
      wt(4);
      scl_o = 1'b1;
      wt(8);
      pull_o = 1'b0;
      wt(8);
   endtask
endmodule

// ---- testbench/two_wire_register_slave_tb_top.sv ----
`timescale 1ns/100ps
module two_wire_register_slave_tb_top;
   logic        clk;
   logic        external_clock_in;
   logic        rst;
   logic        grst_n;
   logic        slp;
   logic        scl;
   logic        pull;
   logic        oe;
   logic        sdo;
   logic        wr;
   logic [7:0]  wa;
   logic [7:0]  wd;
   logic        asl;
   logic        sda;
   logic [31:0] rnd;
   logic [7:0]  q;
   logic        k;
   int          err_total;
   int          checked;
   int          wr_seen;
   localparam logic [7:0] WRA = {twrs_pkg::TWRS_DEV_ADDR, 1'b0};
   localparam logic [7:0] RDA = {twrs_pkg::TWRS_DEV_ADDR, 1'b1};
   // Pull-up wins unless someone pulls low
   assign sda = !pull && (oe ? sdo : 1'b1);
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      external_clock_in = 1'b0;
      #37;
      forever #80 external_clock_in = ~external_clock_in;
   end
   always @(posedge external_clock_in)
      if (wr === 1'b1)
         wr_seen++;
   two_wire_register_slave u_two_wire_register_slave
   (
      .clock_i(clk), .sys_rst_i(rst), .global_reset_low_i(grst_n), .external_clock_in_i(external_clock_in),
      .sleep_i(slp), .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe), .core_wr_o(wr),
      .core_wr_addr_o(wa), .core_wr_data_o(wd), .core_asleep_o(asl)
   );
   twrs_master u_twrs_master (.clock_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
   endfunction
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e)
      begin
         err_total++;
         $display("BAD %0t %h %h", $time, s, e);
      end
   endtask
   task automatic test_done;
      if (err_total == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d, input logic nak);
      u_twrs_master.start();
      u_twrs_master.byte_x(dev, 1'b1, q, k);
      chk({7'h00, k}, {7'h00, nak});
      if (!nak)
      begin
         u_twrs_master.byte_x(a, 1'b1, q, k);
         chk({7'h00, k}, 8'h00);
         u_twrs_master.byte_x(d, 1'b1, q, k);
         chk({7'h00, k}, 8'h00);
      end
      u_twrs_master.stop();
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic set);
      u_twrs_master.start();
      if (set)
      begin
         u_twrs_master.byte_x(WRA, 1'b1, q, k);
         u_twrs_master.byte_x(a, 1'b1, q, k);
         chk({7'h00, k}, 8'h00);
         u_twrs_master.start();
      end
      u_twrs_master.byte_x(RDA, 1'b1, q, k);
      chk({7'h00, k}, 8'h00);
      u_twrs_master.byte_x(8'hff, 1'b1, q, k);
      chk(q, e);
      u_twrs_master.stop();
   endtask
   initial
   begin
      err_total = 0;
      checked = 0;
      wr_seen = 0;
      rnd = 32'h30b3;
      rst = 1'b1;
      grst_n = 1'b0;
      slp = 1'b0;
      wt(16);
      rst = 1'b0;
      wt(twrs_pkg::TWRS_RST_LOW_MIN_CYC - 16);
      grst_n = 1'b1;
      wt(4);
      for (int i = 0; i < 4; i++)
      begin
         rnd = nxt(rnd);
         wr_reg(WRA, (i == 0) ? 8'hff : rnd[7:0], rnd[15:8], 1'b0);
         wt(100);
         chk(wa, (i == 0) ? 8'hff : rnd[7:0]);
         chk(wd, rnd[15:8]);
         chk(wr_seen[7:0], 8'(i + 1));
         rd_reg((i == 0) ? 8'hff : rnd[7:0], rnd[15:8], 1'b1);
      end
      wr_reg({7'h75, 1'b0}, 8'h00, 8'h00, 1'b1);
      wr_reg({7'h34, 1'b0}, 8'h00, 8'h00, 1'b1);
      chk(wr_seen[7:0], 8'h04);
      slp = 1'b1;
      wt(100);
      chk({7'h00, asl}, 8'h01);
      wr_reg(WRA, 8'h10, 8'h5a, 1'b0);
      wt(100);
      chk(wr_seen[7:0], 8'h04);
      rd_reg(8'h10, 8'h5a, 1'b1);
      slp = 1'b0;
      wt(100);
      chk({7'h00, asl}, 8'h00);
      wr_reg(WRA, 8'h20, 8'hc3, 1'b0);
      wr_reg(WRA, 8'h1f, 8'h3c, 1'b0);
      rd_reg(8'h00, 8'hc3, 1'b0);
      grst_n = 1'b0;
      wt(twrs_pkg::TWRS_RST_LOW_MIN_CYC);
      grst_n = 1'b1;
      wt(4);
      rd_reg(8'h00, twrs_pkg::TWRS_REG_RST, 1'b0);
      rd_reg(8'h10, twrs_pkg::TWRS_REG_RST, 1'b1);
      test_done();
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      err_total++;
      test_done();
   end
endmodule
